/* src/sgc_global_ctrl.sv */
// switch global control bank: vlan, priority, mirroring, switch mii, storm
// assumes a classic wishbone master, synchronous strap and traffic inputs
//
// What this block does
// - vlan enable bit turns 802.1Q forwarding on; resets to zero.
// - two-bit scheme: strict high first, or 10:1, 5:1, 2:1 ratios.
// - and-mode mirrors only when source and destination both match.
// - or-mode, the reset value, mirrors when either port matches.
// - mii duplex bit: one is half duplex, zero is full duplex.
// - mii flow bit enables full duplex flow control on that port.
// - mii speed bit: one is 10 Mbit/s, zero is 100 Mbit/s.
// - null vlan id replaced by the port's id when enabled and the vlan enable bit is set.
// - 11-bit storm threshold, high three bits and low eight bits.
// - storm period is 500 ms at 10 Mbit/s, 67 ms at 100.
// - threshold resets to 0x063.
module sgc_global_ctrl #(
  parameter int unsigned PERIOD_10_CYC  = sgc_pkg::PERIOD_10_CYC,
  parameter int unsigned PERIOD_100_CYC = sgc_pkg::PERIOD_100_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wb_cyc,
  input  wire logic             wb_stb,
  input  wire logic             wb_we,
  input  wire logic [7:0]       wb_adr,
  input  wire logic [3:0]       wb_sel,
  input  wire logic [31:0]      wb_dat_w,
  output logic [31:0]           wb_dat_r,
  output logic                  wb_ack,
  input  wire logic             duplex_strap_input,
  input  wire logic             flow_ctrl_strap_input,
  input  wire logic             speed_strap_input,
  output sgc_pkg::sgc_cfg_type  cfg_r,
  input  wire logic             sched_slot,
  input  wire logic             hi_pending,
  input  wire logic             lo_pending,
  output logic                  grant_hi_r,
  output logic                  grant_lo_r,
  input  wire logic             pkt_valid,
  input  wire logic             src_match,
  input  wire logic             dst_match,
  output logic                  mirror_r,
  input  wire logic             vid_valid,
  input  wire logic [11:0]      rx_vid,
  input  wire logic [11:0]      port_vid,
  output logic                  vid_valid_r,
  output logic [11:0]           vid_out_r,
  input  wire logic             blk_req,
  output logic                  blk_ok_r,
  output logic                  blk_drop_r,
  output logic                  period_tick_r
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_s_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_s_n    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_s_n    <= rst_meta_r;
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic [7:0] vpm_r;
  logic [7:0] mii_r;
  logic [7:0] storm_lo_r;
  logic [7:0] fta_r;
  logic [7:0] ftb_r;
  logic       strap_done_r;

  wire       req_new  = wb_cyc & wb_stb & ~wb_ack;
  wire       aligned  = wb_adr[1:0] == 2'h0;
  wire [5:0] idx      = wb_adr[7:2];
  wire       hit_vpm  = aligned & (idx == sgc_pkg::IDX_VPM);
  wire       hit_mii  = aligned & (idx == sgc_pkg::IDX_MII);
  wire       hit_slo  = aligned & (idx == sgc_pkg::IDX_STORM_LO);
  wire       hit_fta  = aligned & (idx == sgc_pkg::IDX_FTA);
  wire       hit_ftb  = aligned & (idx == sgc_pkg::IDX_FTB);
  // writes before the strap capture are acked and dropped so the straps never overwrite software
  wire       wr_ok    = req_new & wb_we & wb_sel[0] & strap_done_r;
  wire [7:0] wd       = wb_dat_w[7:0];

  // unmapped addresses still ack and read zero, so the bus never hangs
  wire [7:0] rd_byte  = hit_vpm ? vpm_r :
                        hit_mii ? mii_r :
                        hit_slo ? storm_lo_r :
                        hit_fta ? fta_r :
                        hit_ftb ? ftb_r : 8'h00;

  // straps land on the first edge after release
  wire [7:0] strap_mii = {1'b0, duplex_strap_input, flow_ctrl_strap_input, speed_strap_input,
                          mii_r[3:0]};

  wire [7:0] vpm_nxt   = (wr_ok & hit_vpm) ? wd : vpm_r;
  wire [7:0] mii_nxt   = !strap_done_r ? strap_mii : (wr_ok & hit_mii) ? wd : mii_r;
  wire [7:0] slo_nxt   = (wr_ok & hit_slo) ? wd : storm_lo_r;
  wire [7:0] fta_nxt   = (wr_ok & hit_fta) ? wd : fta_r;
  wire [7:0] ftb_nxt   = (wr_ok & hit_ftb) ? wd : ftb_r;

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      wb_ack       <= 1'b0;
      wb_dat_r     <= 32'h0000_0000;
      strap_done_r <= 1'b0;
    end else begin
      wb_ack       <= req_new;
      wb_dat_r     <= req_new ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      strap_done_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      vpm_r      <= sgc_pkg::RST_VPM;
      mii_r      <= sgc_pkg::RST_MII;
      storm_lo_r <= sgc_pkg::RST_STORM_LO;
      fta_r      <= sgc_pkg::RST_FTA;
      ftb_r      <= sgc_pkg::RST_FTB;
    end else begin
      vpm_r      <= vpm_nxt;
      mii_r      <= mii_nxt;
      storm_lo_r <= slo_nxt;
      fta_r      <= fta_nxt;
      ftb_r      <= ftb_nxt;
    end
  end

  // ****************************************************************
  // configuration out
  // ****************************************************************
  sgc_pkg::sgc_cfg_type cfg_nxt;

  assign cfg_nxt.vlan_en      = vpm_nxt[sgc_pkg::VLAN_EN_BIT];
  assign cfg_nxt.prio_scheme  = vpm_nxt[sgc_pkg::PRIO_LSB +: 2];
  assign cfg_nxt.mirror_and   = vpm_nxt[sgc_pkg::MIRROR_BIT];
  assign cfg_nxt.mii_half_dup = mii_nxt[sgc_pkg::DUPLEX_BIT];
  assign cfg_nxt.mii_flow_en  = mii_nxt[sgc_pkg::FLOW_BIT];
  assign cfg_nxt.mii_10m      = mii_nxt[sgc_pkg::SPEED_BIT];
  assign cfg_nxt.null_vid_rep = mii_nxt[sgc_pkg::NULL_VID_BIT];
  assign cfg_nxt.storm_thr    = {mii_nxt[sgc_pkg::STORM_HI_LSB +: 3], slo_nxt};

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n)
      cfg_r <= '{vlan_en: 1'b0, prio_scheme: 2'h0, mirror_and: 1'b0, mii_half_dup: 1'b0,
                 mii_flow_en: 1'b0, mii_10m: 1'b0, null_vid_rep: 1'b0,
                 storm_thr: {sgc_pkg::RST_MII[2:0], sgc_pkg::RST_STORM_LO}};
    else
      cfg_r <= cfg_nxt;
  end

  // ****************************************************************
  // egress scheduler
  // ****************************************************************
  sgc_pkg::sgc_sched_state_type state_r;
  sgc_pkg::sgc_sched_state_type state_nxt;
  logic [3:0]                   hi_run_r;
  logic [3:0]                   weight;

  always_comb begin
    case (cfg_r.prio_scheme)
      sgc_pkg::PRIO_10_1: weight = sgc_pkg::WEIGHT_10;
      sgc_pkg::PRIO_5_1:  weight = sgc_pkg::WEIGHT_5;
      sgc_pkg::PRIO_2_1:  weight = sgc_pkg::WEIGHT_2;
      default:            weight = 4'hF;
    endcase
  end

  wire strict  = cfg_r.prio_scheme == sgc_pkg::PRIO_STRICT;
  wire take_hi = hi_pending & (strict | ~lo_pending | (hi_run_r < weight));
  wire take_lo = lo_pending & ~take_hi;

  always_comb begin
    case ({sched_slot, take_hi, take_lo})
      3'b110:  state_nxt = sgc_pkg::SCH_HIGH;
      3'b101:  state_nxt = sgc_pkg::SCH_LOW;
      default: state_nxt = sgc_pkg::SCH_IDLE;
    endcase
  end

  wire [3:0] hi_run_nxt = (state_nxt == sgc_pkg::SCH_LOW)  ? 4'h0 :
                          (state_nxt == sgc_pkg::SCH_HIGH && hi_run_r != 4'hF) ? hi_run_r + 4'h1 :
                          hi_run_r;

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_r    <= sgc_pkg::SCH_IDLE;
      hi_run_r   <= 4'h0;
      grant_hi_r <= 1'b0;
      grant_lo_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      hi_run_r   <= hi_run_nxt;
      grant_hi_r <= state_nxt == sgc_pkg::SCH_HIGH;
      grant_lo_r <= state_nxt == sgc_pkg::SCH_LOW;
    end
  end

  // ****************************************************************
  // mirroring and vlan id handling
  // ****************************************************************
  // match mode
  wire mirror_hit = cfg_r.mirror_and ? (src_match & dst_match) : (src_match | dst_match);
  // null id only rewritten in vlan mode
  wire vid_swap   = cfg_r.vlan_en & cfg_r.null_vid_rep & (rx_vid == 12'h000);

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      mirror_r    <= 1'b0;
      vid_valid_r <= 1'b0;
      vid_out_r   <= 12'h000;
    end else begin
      mirror_r    <= pkt_valid & mirror_hit;
      vid_valid_r <= vid_valid;
      vid_out_r   <= vid_swap ? port_vid : rx_vid;
    end
  end

  // ****************************************************************
  // storm meter
  // ****************************************************************
  // period follows mii speed
  sgc_storm_meter #(
    .PERIOD_10_CYC  (PERIOD_10_CYC),
    .PERIOD_100_CYC (PERIOD_100_CYC)
  ) u_storm (
    .clk           (clk),
    .rst_n         (rst_s_n),
    .speed_10      (cfg_r.mii_10m),
    .threshold     (cfg_r.storm_thr),
    .blk_req       (blk_req),
    .blk_ok_r      (blk_ok_r),
    .blk_drop_r    (blk_drop_r),
    .period_tick_r (period_tick_r)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  vlan_write_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    wr_ok && hit_vpm |=> ##1 cfg_r.vlan_en == $past(wd[7], 2))
    else $error("vlan enable does not follow write");

  strict_hi_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    sched_slot && strict && hi_pending |=> grant_hi_r && !grant_lo_r)
    else $error("strict mode did not serve high first");

  ratio_low_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    sched_slot && !strict && hi_pending && lo_pending && hi_run_r >= weight |=> grant_lo_r)
    else $error("ratio mode starved low queue");

  mirror_and_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    pkt_valid && cfg_r.mirror_and && !(src_match && dst_match) |=> !mirror_r)
    else $error("and mode mirrored a half match");

  mirror_or_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    pkt_valid && !cfg_r.mirror_and && (src_match || dst_match) |=> mirror_r)
    else $error("or mode missed a match");

  strap_load_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    !strap_done_r |=> ##1 cfg_r.mii_half_dup == $past(duplex_strap_input, 2)
      && cfg_r.mii_flow_en == $past(flow_ctrl_strap_input, 2) && cfg_r.mii_10m == $past(speed_strap_input, 2))
    else $error("mii bits not loaded from straps");

  null_vid_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    vid_valid && cfg_r.vlan_en && cfg_r.null_vid_rep && rx_vid == 12'h000
      |=> vid_valid_r && vid_out_r == $past(port_vid))
    else $error("null vlan id not replaced");

  storm_reset_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    !strap_done_r |=> cfg_r.storm_thr == 11'h063)
    else $error("storm threshold reset value wrong");

  ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");

  ratio_cover_c:  cover property (@(posedge clk) disable iff (!rst_s_n) !strict && grant_lo_r);
  mirror_cover_c: cover property (@(posedge clk) disable iff (!rst_s_n) cfg_r.mirror_and && mirror_r);
  vid_cover_c:    cover property (@(posedge clk) disable iff (!rst_s_n) vid_swap);

endmodule

/* src/sgc_pkg.sv */
// constants, field layout and carrier types for the switch global control bank
// assumes a 125 MHz system clock and a byte-wide register file behind wishbone
package sgc_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] IDX_VPM      = 6'h05;
  localparam logic [5:0] IDX_MII      = 6'h06;
  localparam logic [5:0] IDX_STORM_LO = 6'h07;
  localparam logic [5:0] IDX_FTA      = 6'h08;
  localparam logic [5:0] IDX_FTB      = 6'h09;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int VLAN_EN_BIT   = 7;
  localparam int PRIO_LSB      = 2;
  localparam int MIRROR_BIT    = 0;
  localparam int DUPLEX_BIT    = 6;
  localparam int FLOW_BIT      = 5;
  localparam int SPEED_BIT     = 4;
  localparam int NULL_VID_BIT  = 3;
  localparam int STORM_HI_LSB  = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_VPM      = 8'h00;
  localparam logic [7:0] RST_MII      = 8'h00;
  localparam logic [7:0] RST_STORM_LO = 8'h63;
  localparam logic [7:0] RST_FTA      = 8'h4E;
  localparam logic [7:0] RST_FTB      = 8'h24;

  // ****************************************************************
  // priority scheme codes and high/low ratios
  // ****************************************************************
  localparam logic [1:0] PRIO_STRICT = 2'h0;
  localparam logic [1:0] PRIO_10_1   = 2'h1;
  localparam logic [1:0] PRIO_5_1    = 2'h2;
  localparam logic [1:0] PRIO_2_1    = 2'h3;
  localparam logic [3:0] WEIGHT_10   = 4'hA;
  localparam logic [3:0] WEIGHT_5    = 4'h5;
  localparam logic [3:0] WEIGHT_2    = 4'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint unsigned CLK_HZ          = 125000000;
  localparam longint unsigned PERIOD_10_MS    = 500;
  localparam longint unsigned PERIOD_100_MS   = 67;
  localparam int unsigned     PERIOD_10_CYC   = 32'(PERIOD_10_MS * CLK_HZ / 1000);
  localparam int unsigned     PERIOD_100_CYC  = 32'(PERIOD_100_MS * CLK_HZ / 1000);
  localparam int              PERIOD_W        = 26;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic        vlan_en;
    logic [1:0]  prio_scheme;
    logic        mirror_and;
    logic        mii_half_dup;
    logic        mii_flow_en;
    logic        mii_10m;
    logic        null_vid_rep;
    logic [10:0] storm_thr;
  } sgc_cfg_type;

  typedef enum logic [2:0] {
    SCH_IDLE = 3'b001,
    SCH_HIGH = 3'b010,
    SCH_LOW  = 3'b100
  } sgc_sched_state_type;

endpackage

/* src/sgc_storm_meter.sv */
// broadcast storm meter: counts accepted 64-byte blocks per measurement period
// assumes one block request strobe per cycle at most, threshold stable or slow
module sgc_storm_meter #(
  parameter int unsigned PERIOD_10_CYC  = sgc_pkg::PERIOD_10_CYC,
  parameter int unsigned PERIOD_100_CYC = sgc_pkg::PERIOD_100_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        speed_10,
  input  wire logic [10:0] threshold,
  input  wire logic        blk_req,
  output logic             blk_ok_r,
  output logic             blk_drop_r,
  output logic             period_tick_r
);

  logic [sgc_pkg::PERIOD_W-1:0] period_cnt_r;
  logic [10:0]                  blk_cnt_r;
  wire  [sgc_pkg::PERIOD_W-1:0] period_last;
  wire                          period_end;
  wire                          room;

  assign period_last = speed_10 ? sgc_pkg::PERIOD_W'(PERIOD_10_CYC - 1)
                                : sgc_pkg::PERIOD_W'(PERIOD_100_CYC - 1);
  // speed may rise mid period; >= ends the long period at once
  assign period_end  = period_cnt_r >= period_last;
  assign room        = blk_cnt_r < threshold;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_r  <= '0;
      blk_cnt_r     <= '0;
      blk_ok_r      <= 1'b0;
      blk_drop_r    <= 1'b0;
      period_tick_r <= 1'b0;
    end else begin
      period_cnt_r  <= period_end ? '0 : period_cnt_r + 1'b1;
      period_tick_r <= period_end;
      blk_ok_r      <= blk_req & room;
      blk_drop_r    <= blk_req & ~room;
      if (period_end)
        blk_cnt_r <= '0;
      else if (blk_req && room)
        blk_cnt_r <= blk_cnt_r + 1'b1;
    end
  end

  storm_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    blk_req && !period_end && blk_cnt_r >= threshold |=> !blk_ok_r && blk_drop_r)
    else $error("block accepted above storm threshold");

  storm_cover_c: cover property (@(posedge clk) disable iff (!rst_n) blk_drop_r);

endmodule

/* tb/sgc_global_ctrl_tb.sv */
// self-checking bench for the switch global control bank
// assumes the design package is compiled first; bench drives every port itself
module sgc_global_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  logic dup_s = 1'b1, flow_s = 1'b0, spd_s = 1'b1;
  logic slot = 1'b0, hi_p = 1'b0, lo_p = 1'b0, g_hi, g_lo;
  logic pkt_v = 1'b0, src_m = 1'b0, dst_m = 1'b0, mir;
  logic vid_v = 1'b0, vid_vr;
  logic [11:0] rx_vid = 12'h000, port_vid = 12'h000, vid_o;
  logic blk_req = 1'b0, blk_ok, blk_drop, tick;
  sgc_pkg::sgc_cfg_type cfg_r;
  int mismatches = 0, samples_checked = 0;
  logic [31:0] rd;
  // short periods keep the run small
  sgc_global_ctrl #(.PERIOD_10_CYC(200), .PERIOD_100_CYC(50)) i_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .duplex_strap_input(dup_s), .flow_ctrl_strap_input(flow_s), .speed_strap_input(spd_s),
    .cfg_r(cfg_r), .sched_slot(slot), .hi_pending(hi_p), .lo_pending(lo_p), .grant_hi_r(g_hi),
    .grant_lo_r(g_lo), .pkt_valid(pkt_v), .src_match(src_m), .dst_match(dst_m), .mirror_r(mir),
    .vid_valid(vid_v), .rx_vid(rx_vid), .port_vid(port_vid), .vid_valid_r(vid_vr), .vid_out_r(vid_o),
    .blk_req(blk_req), .blk_ok_r(blk_ok), .blk_drop_r(blk_drop), .period_tick_r(tick));
  always #4 clk = ~clk;
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_sel <= 4'h1;
    wb_dat_w <= {24'h000000, dat};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_r;
    if (n >= 50) check(32'h0, 32'h1);
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    wb_xfer(1'b0, adr, 8'h00);
    check(rd, {24'h000000, exp});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    check(cfg_r.storm_thr, 11'h063);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(8'h14, 8'h00);
    check(cfg_r.prio_scheme, 2'h0);
    check(cfg_r.mirror_and, 1'b0);
    rd_chk(8'h18, 8'h50);
    check({cfg_r.mii_half_dup, cfg_r.mii_flow_en, cfg_r.mii_10m}, 3'h5);
    rd_chk(8'h1C, 8'h63);
    // factory registers are only read, never written
    rd_chk(8'h20, 8'h4E);
    rd_chk(8'h24, 8'h24);
    rd_chk(8'h28, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_regs;
    // reserved bits written as zero
    wb_xfer(1'b1, 8'h14, 8'h8D);
    check({cfg_r.vlan_en, cfg_r.prio_scheme, cfg_r.mirror_and}, 4'hF);
    rd_chk(8'h14, 8'h8D);
    wb_xfer(1'b1, 8'h18, 8'h2D);
    wb_xfer(1'b1, 8'h1C, 8'hA5);
    check({cfg_r.mii_half_dup, cfg_r.mii_flow_en, cfg_r.mii_10m}, 3'h2);
    check(cfg_r.null_vid_rep, 1'b1);
    check(cfg_r.storm_thr, 11'h5A5);
    wb_xfer(1'b1, 8'h18, 8'h50);
    check({cfg_r.mii_half_dup, cfg_r.mii_flow_en, cfg_r.mii_10m}, 3'h5);
    wb_xfer(1'b1, 8'h28, 8'hFF);
    rd_chk(8'h28, 8'h00);
    rd_chk(8'h14, 8'h8D);
    $display("test regs done");
  endtask
  task automatic t_sched;
    int lows, n;
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : (c == 1) ? 11 : (c == 2) ? 6 : 3;
      wb_xfer(1'b1, 8'h14, {4'h0, c[1:0], 2'h0});
      lows = 0;
      @(posedge clk); slot <= 1'b1; hi_p <= 1'b1; lo_p <= 1'b1;
      @(posedge clk);
      // any window of three ratio periods holds exactly three low grants
      for (int i = 0; i < 3 * n + ((c == 0) ? 20 : 0); i++) begin
        @(posedge clk);
        lows += int'(g_lo);
        check(g_hi ^ g_lo, 1'b1);
      end
      check(lows, (c == 0) ? 0 : 3);
      slot <= 1'b0; hi_p <= 1'b0; lo_p <= 1'b0;
    end
    @(posedge clk); slot <= 1'b1;
    @(posedge clk); slot <= 1'b0;
    @(posedge clk);
    check({g_hi, g_lo}, 2'h0);
    $display("test sched done");
  endtask
  task automatic t_mirror;
    for (int k = 0; k < 8; k++) begin
      wb_xfer(1'b1, 8'h14, {7'h00, k[2]});
      @(posedge clk); pkt_v <= 1'b1; src_m <= k[1]; dst_m <= k[0];
      @(posedge clk); pkt_v <= 1'b0;
      @(posedge clk);
      check(mir, k[2] ? (k[1] & k[0]) : (k[1] | k[0]));
    end
    $display("test mirror done");
  endtask
  task automatic t_vid;
    logic [11:0] rxv;
    port_vid <= 12'hABC;
    for (int k = 0; k < 8; k++) begin
      rxv = k[0] ? 12'h000 : 12'h123;
      wb_xfer(1'b1, 8'h14, {k[2], 7'h00});
      wb_xfer(1'b1, 8'h18, {4'h5, k[1], 3'h0});
      @(posedge clk); vid_v <= 1'b1; rx_vid <= rxv;
      @(posedge clk); vid_v <= 1'b0;
      @(posedge clk);
      check(vid_vr, 1'b1);
      check(vid_o, (k[2] & k[1] & k[0]) ? 12'hABC : rxv);
    end
    $display("test vid done");
  endtask
  // mid-run reset with the opposite strap levels
  task automatic t_restrap;
    @(posedge clk); rst_n <= 1'b0; dup_s <= 1'b0; flow_s <= 1'b1; spd_s <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(cfg_r.storm_thr, 11'h063);
    check({cfg_r.mii_half_dup, cfg_r.mii_flow_en, cfg_r.mii_10m}, 3'h2);
    rd_chk(8'h18, 8'h20);
    rd_chk(8'h14, 8'h00);
    $display("test restrap done");
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 500);
  endtask
  task automatic t_storm;
    int n, oks;
    wb_xfer(1'b1, 8'h18, 8'h50);
    wb_xfer(1'b1, 8'h1C, 8'h03);
    wait_tick(n);
    oks = 0;
    blk_req <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) blk_req <= 1'b0;
      @(posedge clk);
      oks += int'(blk_ok);
      check(blk_ok ^ blk_drop, 1'b1);
    end
    check(oks, 3);
    wait_tick(n);
    wait_tick(n);
    check(n, 200);
    wb_xfer(1'b1, 8'h18, 8'h40);
    wait_tick(n);
    wait_tick(n);
    check(n, 50);
    $display("test storm done");
  endtask
  // ****************************************************************
  // sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    t_reset();
    t_regs();
    t_sched();
    t_mirror();
    t_vid();
    t_restrap();
    t_storm();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
